/* mgc_map.vh */
// Register offsets, field positions, reset values and timing counts for the gain/checksum bank.
// Assumes a 7-bit word address on the plain register port; included by bare name.
`ifndef MGC_MAP_VH
`define MGC_MAP_VH
`define MGC_ADDR_W 7
`define MGC_PROT_FIRST 7'h31
`define MGC_PROT_LAST 7'h3a
`define MGC_PROT_COUNT 10
`define MGC_OFF_CHECKSUM 7'h3b
`define MGC_OFF_GAIN 7'h3c
`define MGC_OFF_CFGSTART 7'h30
`define MGC_OFF_STATUS0 7'h71
`define MGC_CFGSTART_CHECK 16'h8765
`define MGC_CFGSTART_RESET 16'h6886
`define MGC_GAIN_RESET 16'h0000
`define MGC_CHECKSUM_RESET 16'h0000
`define MGC_STATUS_CSERR_BIT 14
`define MGC_DGAIN_MSB 15
`define MGC_DGAIN_LSB 14
`define MGC_AGAIN_VOLT_THIRD_LSB 12
`define MGC_AGAIN_VOLT_SECOND_LSB 10
`define MGC_AGAIN_VOLT_FIRST_LSB 8
`define MGC_AGAIN_CURR_THIRD_LSB 4
`define MGC_AGAIN_CURR_SECOND_LSB 2
`define MGC_AGAIN_CURR_FIRST_LSB 0
`define MGC_CHECK_PERIOD_NS 1000
`define MGC_CLK_PERIOD_NS 10
`define MGC_CHECK_PERIOD_CYC (`MGC_CHECK_PERIOD_NS / `MGC_CLK_PERIOD_NS)
`endif

/* mgc_checksum_calc.v */
// Combinational byte sum and byte XOR over the ten protected setup words.
// Assumes the words arrive packed, lowest address in the lowest 16 bits.
`include "mgc_map.vh"

module mgc_checksum_calc #(
   parameter COUNT = `MGC_PROT_COUNT
) (
   // Protected words.
   input wire [16*COUNT-1:0] protWords,
   // Result: XOR in the high byte, sum in the low byte.
   output reg [15:0] calcValue
);

   integer i;
   reg [7:0] byteSum;
   reg [7:0] byteXor;

   always @* begin
      byteSum = 8'h00;
      byteXor = 8'h00;
      for (i = 0; i < COUNT; i = i + 1) begin
         byteSum = byteSum + protWords[16*i+8 +: 8] + protWords[16*i +: 8];
         byteXor = byteXor ^ protWords[16*i+8 +: 8] ^ protWords[16*i +: 8];
      end
      calcValue = {byteXor, byteSum};
   end

endmodule // mgc_checksum_calc

/* mgc_gain_checksum.v */
// Gain configuration word and periodic integrity check of the setup register group.
// Assumes a host drives the plain register port on clk_sys; gain codes feed the datapath.
`include "mgc_map.vh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Bits 15:14 pick current digital gain 1, 2, 4 or 8 after decimation.
// - Analog fields: voltage third/second/first 13:12, 11:10, 9:8; current 5:4, 3:2, 1:0.
// - Checksum low byte is the 8-bit sum of all protected bytes.
// - Checksum high byte is the XOR of all protected bytes.
// - Periodic recheck; mismatch with start 8765H sets error flag, warning, interrupt.
module mgc_gain_checksum #(
   parameter CHECK_PERIOD = `MGC_CHECK_PERIOD_CYC
) (
   // Clock and reset.
   input wire clk_sys,
   input wire rst,
   // Register port.
   input wire [`MGC_ADDR_W-1:0] regAddr,
   input wire [15:0] regWrData,
   input wire regWrite,
   input wire regRead,
   output reg [15:0] regRdData,
   // Gain selections to the datapath.
   output reg [3:0] digitalCurrentGain,
   output reg [1:0] analogGainVoltageThird,
   output reg [1:0] analogGainVoltageSecond,
   output reg [1:0] analogGainVoltageFirst,
   output reg [1:0] analogGainCurrentThird,
   output reg [1:0] analogGainCurrentSecond,
   output reg [1:0] analogGainCurrentFirst,
   // Alarm pins.
   output reg warningOutputPin,
   output reg interruptPin
);

   reg [15:0] channelGainConfig;
   reg [15:0] checksumWordSetup;
   reg [15:0] configStartCommand;
   reg [15:0] protRegs [0:`MGC_PROT_COUNT-1];
   reg checksumErrorFlag;
   reg [15:0] periodCount;
   reg [15:0] next_rdData;
   wire [16*`MGC_PROT_COUNT-1:0] protPacked;
   wire [15:0] calcValue;
   wire checkTick;
   wire mismatch;
   wire statusRead;
   integer k;

   // The reload value is cut to the counter width on purpose.
   // Check periods longer than 65536 cycles are therefore not supported.
   localparam [31:0] PERIOD_LAST = CHECK_PERIOD - 1;

   ////////////////////////////////////////////////////////////////////////////
   // One-hot digital gain multiplier: 1, 2, 4 or 8.
   function [3:0] decodeDigital;
      input [1:0] code;
      begin
         decodeDigital = 4'h1 << code;
      end
   endfunction

   // Invalid code 11 is clamped to unity so the datapath never sees an undefined gain.
   function [1:0] sanitizeAnalog;
      input [1:0] code;
      begin
         sanitizeAnalog = (code == 2'h3) ? 2'h0 : code;
      end
   endfunction

   function isProtected;
      input [`MGC_ADDR_W-1:0] a;
      begin
         isProtected = (a >= `MGC_PROT_FIRST) && (a <= `MGC_PROT_LAST);
      end
   endfunction

   // Word index inside the protected group; only meaningful where isProtected holds.
   function [3:0] protIndex;
      input [`MGC_ADDR_W-1:0] a;
      reg [`MGC_ADDR_W-1:0] offset;
      begin
         offset = a - `MGC_PROT_FIRST;
         protIndex = offset[3:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   genvar g;
   generate
      for (g = 0; g < `MGC_PROT_COUNT; g = g + 1) begin : pack
         assign protPacked[16*g +: 16] = protRegs[g];
      end
   endgenerate

   mgc_checksum_calc #(
      .COUNT(`MGC_PROT_COUNT)
   ) u_calc (
      .protWords(protPacked),
      .calcValue(calcValue)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Check period counter.
   assign checkTick = (periodCount == 16'h0000);
   // The host is trusted to finish the protected group before updating the checksum word;
   // a check landing mid-sequence may flag a transient mismatch, which stays sticky.
   assign mismatch = (configStartCommand == `MGC_CFGSTART_CHECK)
      && (calcValue != checksumWordSetup);

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         periodCount <= 16'h0000;
      end else if (checkTick) begin
         periodCount <= PERIOD_LAST[15:0];
      end else begin
         periodCount <= periodCount - 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         channelGainConfig <= `MGC_GAIN_RESET;
         checksumWordSetup <= `MGC_CHECKSUM_RESET;
         configStartCommand <= `MGC_CFGSTART_RESET;
         for (k = 0; k < `MGC_PROT_COUNT; k = k + 1) begin
            protRegs[k] <= 16'h0000;
         end
      end else begin
         if (regWrite) begin
            if (regAddr == `MGC_OFF_GAIN) begin
               channelGainConfig <= regWrData;
            end
            if (regAddr == `MGC_OFF_CHECKSUM) begin
               checksumWordSetup <= regWrData;
            end
            if (regAddr == `MGC_OFF_CFGSTART) begin
               configStartCommand <= regWrData;
            end
            if (isProtected(regAddr)) begin
               protRegs[protIndex(regAddr)] <= regWrData;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky error flag, cleared by reading the status word.
   assign statusRead = regRead && (regAddr == `MGC_OFF_STATUS0);

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         checksumErrorFlag <= 1'b0;
      end else if (checkTick && mismatch) begin
         // A status read in the same cycle must not hide a fresh mismatch, so the set wins.
         checksumErrorFlag <= 1'b1;
      end else if (statusRead) begin
         checksumErrorFlag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.
   always @* begin
      next_rdData = 16'h0000;
      if (regAddr == `MGC_OFF_GAIN) begin
         next_rdData = channelGainConfig;
      end else if (regAddr == `MGC_OFF_CHECKSUM) begin
         next_rdData = checksumWordSetup;
      end else if (regAddr == `MGC_OFF_CFGSTART) begin
         next_rdData = configStartCommand;
      end else if (regAddr == `MGC_OFF_STATUS0) begin
         next_rdData[`MGC_STATUS_CSERR_BIT] = checksumErrorFlag;
      end else if (isProtected(regAddr)) begin
         next_rdData = protRegs[protIndex(regAddr)];
      end
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         regRdData <= 16'h0000;
      end else begin
         // Read data stand for one cycle only, so an idle port always reads back zero.
         regRdData <= regRead ? next_rdData : 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Gain selections and alarm pins, one cycle behind the registers that feed them.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         digitalCurrentGain <= 4'h1;
         analogGainVoltageThird <= 2'h0;
         analogGainVoltageSecond <= 2'h0;
         analogGainVoltageFirst <= 2'h0;
         analogGainCurrentThird <= 2'h0;
         analogGainCurrentSecond <= 2'h0;
         analogGainCurrentFirst <= 2'h0;
         warningOutputPin <= 1'b0;
         interruptPin <= 1'b0;
      end else begin
         digitalCurrentGain <= decodeDigital(
            channelGainConfig[`MGC_DGAIN_MSB:`MGC_DGAIN_LSB]);
         // Bits 7:6 are never read for any gain.
         analogGainVoltageThird <= sanitizeAnalog(
            channelGainConfig[`MGC_AGAIN_VOLT_THIRD_LSB +: 2]);
         analogGainVoltageSecond <= sanitizeAnalog(
            channelGainConfig[`MGC_AGAIN_VOLT_SECOND_LSB +: 2]);
         analogGainVoltageFirst <= sanitizeAnalog(
            channelGainConfig[`MGC_AGAIN_VOLT_FIRST_LSB +: 2]);
         analogGainCurrentThird <= sanitizeAnalog(
            channelGainConfig[`MGC_AGAIN_CURR_THIRD_LSB +: 2]);
         analogGainCurrentSecond <= sanitizeAnalog(
            channelGainConfig[`MGC_AGAIN_CURR_SECOND_LSB +: 2]);
         analogGainCurrentFirst <= sanitizeAnalog(
            channelGainConfig[`MGC_AGAIN_CURR_FIRST_LSB +: 2]);
         warningOutputPin <= checksumErrorFlag;
         interruptPin <= checksumErrorFlag;
      end
   end

endmodule // mgc_gain_checksum

/* mgc_gain_checksum_sva.sv */
// Port assertions for the gain and checksum bank.
// Assumes a bind to mgc_gain_checksum; sees only its ports.
`include "mgc_map.vh"
module mgc_gain_checksum_sva #(parameter CHECK_PERIOD = 4) (
   // Clock, reset and register port.
   input wire clk_sys,
   input wire rst,
   input wire [`MGC_ADDR_W-1:0] regAddr,
   input wire [15:0] regWrData,
   input wire regWrite,
   input wire regRead,
   input wire [15:0] regRdData,
   // Gains and alarm pins.
   input wire [3:0] digitalCurrentGain,
   input wire [1:0] analogGainVoltageThird,
   input wire [1:0] analogGainVoltageSecond,
   input wire [1:0] analogGainVoltageFirst,
   input wire [1:0] analogGainCurrentThird,
   input wire [1:0] analogGainCurrentSecond,
   input wire [1:0] analogGainCurrentFirst,
   input wire warningOutputPin,
   input wire interruptPin
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   function automatic [1:0] cl(input [1:0] c);
      cl = (c == 2'h3) ? 2'h0 : c;
   endfunction
   wire [15:0] d = regWrData;
   wire [11:0] ag = {analogGainVoltageThird, analogGainVoltageSecond, analogGainVoltageFirst,
      analogGainCurrentThird, analogGainCurrentSecond, analogGainCurrentFirst};
   wire [11:0] want = {cl(d[13:12]), cl(d[11:10]), cl(d[9:8]), cl(d[5:4]), cl(d[3:2]), cl(d[1:0])};
   wire gainWr = regWrite && regAddr == `MGC_OFF_GAIN;
   wire statusRd = regRead && regAddr == `MGC_OFF_STATUS0;
   reg [15:0] lastGain;
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lastGain <= `MGC_GAIN_RESET;
      end else if (gainWr) begin
         lastGain <= regWrData;
      end
   end
   sequence s_gainWr; regWrite && regAddr == `MGC_OFF_GAIN; endsequence
   sequence s_gainRd; regRead && regAddr == `MGC_OFF_GAIN; endsequence
   property p_dgain;
      s_gainWr |-> ##2 digitalCurrentGain == (4'h1 << $past(d[15:14], 2));
   endproperty
   a_dgain: assert property (p_dgain) else $error("digital gain wrong");
   property p_onehot; $onehot(digitalCurrentGain); endproperty
   a_onehot: assert property (p_onehot) else $error("digital gain not one-hot");
   property p_again; s_gainWr |-> ##2 ag == $past(want, 2); endproperty
   a_again: assert property (p_again) else $error("analog gain wrong");
   property p_noinv; !(|(ag & (ag >> 1) & 12'h555)); endproperty
   a_noinv: assert property (p_noinv) else $error("invalid analog code out");
   property p_hold; !gainWr |-> ##2 $stable({ag, digitalCurrentGain}); endproperty
   a_hold: assert property (p_hold) else $error("gain moved without write");
   property p_readback; s_gainRd |=> regRdData == $past(lastGain); endproperty
   a_readback: assert property (p_readback) else $error("gain readback wrong");
   property p_pins; warningOutputPin == interruptPin; endproperty
   a_pins: assert property (p_pins) else $error("alarm pins differ");
   property p_flag; regRead && regAddr == `MGC_OFF_STATUS0
      |=> regRdData[`MGC_STATUS_CSERR_BIT] == warningOutputPin; endproperty
   a_flag: assert property (p_flag) else $error("error flag and pin differ");
   property p_sticky; !statusRd ##1 warningOutputPin |=> warningOutputPin; endproperty
   a_sticky: assert property (p_sticky) else $error("warning dropped without status read");
endmodule // mgc_gain_checksum_sva

/* mgc_host_model.sv */
// Host model driving the register port.
// Assumes one clock; each request lasts one cycle after a rising edge.
`include "mgc_map.vh"
module mgc_host_model (
   // Clock and register port.
   input wire clk_sys,
   output logic [`MGC_ADDR_W-1:0] regAddr = 7'h7f,
   output logic [15:0] regWrData = 16'h0,
   output logic regWrite = 1'b0,
   output logic regRead = 1'b0,
   input wire [15:0] regRdData
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] prot [10] = '{default: 16'h0};
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk_sys);
      regWrite <= 1'b0;
      // Released data is inverted so a stale word never looks fresh.
      regWrData <= ~d;
      if (a >= `MGC_PROT_FIRST && a <= `MGC_PROT_LAST) prot[a - `MGC_PROT_FIRST] = d;
      #1;
   endtask
   task automatic rd(input logic [6:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1 d = regRdData;
   endtask
   function automatic logic [15:0] csum();
      logic [7:0] s;
      logic [7:0] x;
      s = 8'h0;
      x = 8'h0;
      for (int i = 0; i < 10; i++) begin
         s = s + prot[i][15:8] + prot[i][7:0];
         x = x ^ prot[i][15:8] ^ prot[i][7:0];
      end
      return {x, s};
   endfunction
   task automatic setup(input logic [15:0] bad);
      for (int i = 0; i < `MGC_PROT_COUNT; i++) begin
         wr(`MGC_PROT_FIRST + 7'(i), 16'h9b3d + 16'(i * 16'h01f7));
      end
      wr(`MGC_OFF_CHECKSUM, csum() ^ bad);
   endtask
endmodule // mgc_host_model

/* tb_mgc_gain_checksum.sv */
// Self-checking bench for the gain and checksum bank.
// Assumes the host model drives the port; the checker is bound below.
`include "mgc_map.vh"
module tb_mgc_gain_checksum;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CHECK_PERIOD = 4;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   wire [6:0] regAddr;
   wire [15:0] regWrData, regRdData;
   wire regWrite, regRead, warningOutputPin, interruptPin;
   wire [3:0] digitalCurrentGain;
   wire [1:0] analogGainVoltageThird, analogGainVoltageSecond, analogGainVoltageFirst;
   wire [1:0] analogGainCurrentThird, analogGainCurrentSecond, analogGainCurrentFirst;
   wire [15:0] gains = {digitalCurrentGain, analogGainVoltageThird, analogGainVoltageSecond,
      analogGainVoltageFirst, analogGainCurrentThird, analogGainCurrentSecond,
      analogGainCurrentFirst};
   wire [15:0] pins = {14'h0, warningOutputPin, interruptPin};
   int n_fail = 0;
   int total_checks = 0;
   int cyc = 0;
   logic [15:0] rdv;
   logic [15:0] gw [4] = '{16'h0000, 16'h6a26, 16'h95c9, 16'hf1e7};
   logic [15:0] ge [4] = '{16'h1000, 16'h2aa6, 16'h4549, 16'h8064};
   logic [15:0] bad [4] = '{16'h0000, 16'h0001, 16'h0100, 16'h0001};
   logic [15:0] st [4] = '{16'h8765, 16'h8765, 16'h8765, 16'h6886};
   logic [15:0] ef [4] = '{16'h0, 16'h3, 16'h3, 16'h0};
   mgc_gain_checksum #(.CHECK_PERIOD(CHECK_PERIOD)) uut (.clk_sys, .rst, .regAddr, .regWrData,
      .regWrite, .regRead, .regRdData, .digitalCurrentGain, .analogGainVoltageThird,
      .analogGainVoltageSecond, .analogGainVoltageFirst, .analogGainCurrentThird,
      .analogGainCurrentSecond, .analogGainCurrentFirst, .warningOutputPin, .interruptPin);
   mgc_host_model host (.clk_sys, .regAddr, .regWrData, .regWrite, .regRead, .regRdData);
   always #5 clk_sys = ~clk_sys;
   task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task summarize();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         summarize();
      end
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      chk("reset gains", gains, 16'h1000);
      chk("reset pins", pins, 16'h0);
      host.rd(`MGC_OFF_CFGSTART, rdv);
      chk("reset start", rdv, `MGC_CFGSTART_RESET);
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         host.wr(`MGC_OFF_GAIN, gw[i]);
         @(posedge clk_sys);
         #1;
         chk("gain outputs", gains, ge[i]);
         host.rd(`MGC_OFF_GAIN, rdv);
         chk("gain word", rdv, gw[i]);
      end
      $display("gain table done");
      for (int i = 0; i < 4; i++) begin
         host.setup(bad[i]);
         host.rd(`MGC_OFF_CHECKSUM, rdv);
         chk("checksum word", rdv, host.csum() ^ bad[i]);
         host.wr(`MGC_OFF_CFGSTART, st[i]);
         host.rd(`MGC_OFF_STATUS0, rdv);
         repeat (2 * CHECK_PERIOD + 4) @(posedge clk_sys);
         #1;
         chk("alarm pins", pins, ef[i]);
         host.rd(`MGC_OFF_STATUS0, rdv);
         chk("error flag", rdv & 16'h4000, ef[i][0] ? 16'h4000 : 16'h0);
      end
      $display("checksum table done");
      host.rd(7'h7f, rdv);
      chk("unmapped read", rdv, 16'h0);
      @(posedge clk_sys);
      rst <= 1'b1;
      @(posedge clk_sys);
      #1;
      chk("mid reset gains", gains, 16'h1000);
      @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk("after reset gains", gains, 16'h1000);
      chk("after reset pins", pins, 16'h0);
      host.rd(`MGC_OFF_GAIN, rdv);
      chk("after reset gain word", rdv, `MGC_GAIN_RESET);
      $display("refusal and reset test done");
      summarize();
   end
endmodule // tb_mgc_gain_checksum
bind mgc_gain_checksum mgc_gain_checksum_sva #(.CHECK_PERIOD(CHECK_PERIOD)) sva (.clk_sys, .rst,
   .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .digitalCurrentGain,
   .analogGainVoltageThird, .analogGainVoltageSecond, .analogGainVoltageFirst,
   .analogGainCurrentThird, .analogGainCurrentSecond, .analogGainCurrentFirst,
   .warningOutputPin, .interruptPin);
